//--- design/tscp_port.sv
// serial control port of the transceiver with its register store
// Function
// - 4-wire mode with separate in and out lines
// - 3-wire mode with one shared data line
// - write frame is 24 continuous bits
// - first bit selects read or write
// - next 15 bits are register address
// - write stores last 8 bits at address
// - read returns 8 bits on mode's line
`timescale 1ns/1ps
module tscp_port import tscp_pkg::*; #(
  parameter int NUM_REGS = 256
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst,
  // link clock and select
  input wire logic sclk,
  input wire logic csN,
  // mode: high selects 3-wire
  input wire logic threeWire,
  // serial data pins
  input wire logic serialDin,
  input wire logic serialBidirDataIn,
  output logic serialDout,
  output logic serialDoutOe,
  output logic serialBidirDataOut,
  output logic serialBidirDataOe,
  // core view of the register store
  output logic [7:0] cfgAddrSeen,
  output logic writeSeen
);
  localparam int IW = $clog2(NUM_REGS);

  // --------------------------------------------------------------------
  // link domain: shift register on sclk
  // --------------------------------------------------------------------
  // link clock only runs inside frames, so state is reset by csN high
  logic [4:0] bitCnt_q, bitCnt_d;
  logic [22:0] shift_q, shift_d;
  logic isRead_q, isRead_d;
  logic [7:0] rdShift_q, rdShift_d;
  logic wrTog_q, wrTog_d;
  tscp_wreq_t wreq_q, wreq_d;
  logic [7:0] rdData;
  logic [IW-1:0] rdIdx;
  logic readPhase;

  // --------------------------------------------------------------------
  // link domain: data line select
  // --------------------------------------------------------------------
  // mode picks the line the master drives; the other is left unread
  function automatic logic linkBit();
    return threeWire ? serialBidirDataIn : serialDin;
  endfunction : linkBit

  // full address is taken at the sixteenth edge; bits above the store
  // are dropped, so larger addresses alias onto it
  assign rdIdx = IW'({shift_q[ADDR_BITS-2:0], linkBit()});

  // --------------------------------------------------------------------
  // link domain: frame shifter
  // --------------------------------------------------------------------
  // threeWire and regs are quasi-static between frames on the link side
  always_comb begin
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    isRead_d = isRead_q;
    rdShift_d = rdShift_q;
    // counter saturates, so bits past the frame length are ignored
    if (bitCnt_q < 5'(FRAME_BITS)) begin
      bitCnt_d = bitCnt_q + 5'h01;
      shift_d = {shift_q[21:0], linkBit()};
    end
    if (bitCnt_q == 5'h00) begin
      isRead_d = (linkBit() == DIR_READ);
    end
    if (bitCnt_q == 5'(HEAD_BITS - 1)) begin
      rdShift_d = rdData;
    end else if (bitCnt_q >= 5'(HEAD_BITS)) begin
      rdShift_d = {rdShift_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_q <= CNT_RESET;
      shift_q <= '0;
      isRead_q <= 1'b0;
      rdShift_q <= REG_RESET;
    end else begin
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      isRead_q <= isRead_d;
      rdShift_q <= rdShift_d;
    end
  end

  // --------------------------------------------------------------------
  // link domain: write hand-off
  // --------------------------------------------------------------------
  // the last bit of a write frame flips the toggle; cut frames never do
  always_comb begin
    wrTog_d = wrTog_q;
    wreq_d = wreq_q;
    if (bitCnt_q == 5'(FRAME_BITS - 1) && !isRead_q) begin
      wreq_d.addr = shift_q[21:7];
      wreq_d.data = {shift_q[6:0], linkBit()};
      wrTog_d = ~wrTog_q;
    end
  end

  // word survives the end of frame for the core to take; system reset
  // clears it while the link clock stands still, so release is safe
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      wrTog_q <= 1'b0;
      wreq_q <= '0;
    end else begin
      wrTog_q <= wrTog_d;
      wreq_q <= wreq_d;
    end
  end

  // --------------------------------------------------------------------
  // link domain: read data drive
  // --------------------------------------------------------------------
  // the master owns the line for the sixteen header bits
  assign readPhase = isRead_q && bitCnt_q >= 5'(HEAD_BITS);

  // output drive on falling edge so the master samples stable bits
  tscp_pins_t pins_q, pins_d;
  always_comb begin
    pins_d = '0;
    if (readPhase) begin
      if (threeWire) begin
        pins_d.dioOut = rdShift_q[7];
        pins_d.dioOe = 1'b1;
      end else begin
        pins_d.dout = rdShift_q[7];
        pins_d.doutOe = 1'b1;
      end
    end
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign serialDout = pins_q.dout;
  assign serialDoutOe = pins_q.doutOe;
  assign serialBidirDataOut = pins_q.dioOut;
  assign serialBidirDataOe = pins_q.dioOe;

  // --------------------------------------------------------------------
  // core domain: register store and write commit
  // --------------------------------------------------------------------
  // one toggle edge per committed write; the word is held meanwhile
  logic wrTogSync;
  tscp_sync #(.WIDTH(1)) u_wr_sync (
    .clk(clk),
    .rst(rst),
    .din(wrTog_q),
    .dout(wrTogSync)
  );

  // --------------------------------------------------------------------
  // core domain: register store
  // --------------------------------------------------------------------
  logic wrTogSeen_q, wrTogSeen_d;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] regs_d [NUM_REGS];
  logic [7:0] lastAddr_q, lastAddr_d;
  logic wrPulse_q, wrPulse_d;
  logic hit;

  // request word is stable for two core cycles before the toggle lands
  always_comb begin
    wrTogSeen_d = wrTogSync;
    hit = wrTogSync != wrTogSeen_q;
    regs_d = regs_q;
    lastAddr_d = lastAddr_q;
    wrPulse_d = hit;
    if (hit) begin
      regs_d[IW'(wreq_q.addr)] = wreq_q.data;
      lastAddr_d = wreq_q.addr[7:0];
    end
  end

  // storage clears on reset only; a frame in flight then is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      wrTogSeen_q <= 1'b0;
      lastAddr_q <= REG_RESET;
      wrPulse_q <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else begin
      wrTogSeen_q <= wrTogSeen_d;
      lastAddr_q <= lastAddr_d;
      wrPulse_q <= wrPulse_d;
      regs_q <= regs_d;
    end
  end

  // --------------------------------------------------------------------
  // core domain: outputs and read path
  // --------------------------------------------------------------------
  // read side samples quasi-static storage; master leaves a gap after writes
  // a write landing inside a read frame may return a torn byte
  assign rdData = regs_q[rdIdx];
  assign cfgAddrSeen = lastAddr_q;
  assign writeSeen = wrPulse_q;
endmodule : tscp_port

//--- common/tscp_pkg.sv
// package: constants and carrier types for the transceiver serial control port
package tscp_pkg;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 15;
  localparam int DATA_BITS = 8;
  localparam int HEAD_BITS = 16;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] CNT_RESET = 5'h00;

  // write request handed from the link domain to the core
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } tscp_wreq_t;

  // pin-level output group of the serial data lines
  typedef struct packed {
    logic dout;
    logic doutOe;
    logic dioOut;
    logic dioOe;
  } tscp_pins_t;
endpackage : tscp_pkg

//--- design/tscp_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module tscp_sync import tscp_pkg::*; #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule : tscp_sync

//--- dv/tscp_port_monitor.sv
// checker of the serial control port
`timescale 1ns/1ps
module tscp_port_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // select and mode
  input wire logic csN,
  input wire logic threeWire,
  // watched outputs
  input wire logic writeSeen,
  input wire logic serialDoutOe,
  input wire logic serialBidirDataOe,
  input wire logic [7:0] cfgAddrSeen
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire oe = serialDoutOe || serialBidirDataOe;
  chk_idle_off: assert property (csN |-> !oe)
    else $error("idle drive");
  chk_four_wire: assert property (serialDoutOe |-> !threeWire)
    else $error("wrong line");
  chk_three_wire: assert property (serialBidirDataOe |-> threeWire)
    else $error("wrong line");
  chk_pulse_once: assert property (writeSeen |=> !writeSeen)
    else $error("long pulse");
  chk_frame_held: assert property (writeSeen |-> !$past(csN, 5))
    else $error("short frame");
  chk_late_data: assert property ($rose(oe) |-> !$past(csN, 20))
    else $error("early data");
  chk_oe_hold: assert property ($fell(oe) |-> csN)
    else $error("data dropped");
  chk_addr_moves: assert property (
    $changed(cfgAddrSeen) |-> ##[0:1] (writeSeen || $past(writeSeen)))
    else $error("stray address");
  cover property (writeSeen);
  cover property (serialDoutOe);
  cover property (serialBidirDataOe);
endmodule : tscp_port_monitor

bind tscp_port tscp_port_monitor i_tscp_port_monitor (
  .clk(clk),
  .rst(rst),
  .csN(csN),
  .threeWire(threeWire),
  .writeSeen(writeSeen),
  .serialDoutOe(serialDoutOe),
  .serialBidirDataOe(serialBidirDataOe),
  .cfgAddrSeen(cfgAddrSeen)
);

//--- dv/tscp_master.sv
// serial master model framing transfers into the port
`timescale 1ns/1ps
module tscp_master (
  // device side
  input wire logic threeWire,
  input wire logic serialDout,
  input wire logic serialDoutOe,
  input wire logic serialBidirDataOut,
  input wire logic serialBidirDataOe,
  // link lines
  output logic sclk,
  output logic csN,
  output logic serialDin,
  output logic serialBidirDataIn
);
  logic b = 1'b0;
  initial {sclk, csN} = 2'b01;
  assign serialDin = b;
  // released line toggles so a stale bit never passes as data
  assign serialBidirDataIn = serialBidirDataOe ? serialBidirDataOut : b;
  task automatic xfer(input logic [23:0] f, input int n,
    output logic [7:0] q);
    csN = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      b = f[23] && i < 8 ? ~b : f[i];
      #7.5 sclk = 1'b1;
      q[i % 8] = threeWire ? serialBidirDataIn :
        serialDoutOe ? serialDout : ~serialDout;
      #7.5 sclk = 1'b0;
    end
    csN = 1'b1;
  endtask : xfer
endmodule : tscp_master

//--- dv/testbench.sv
// self-checking bench of the serial control port
`timescale 1ns/1ps
module testbench import tscp_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, threeWire = 1'b0, csN, sclk, hit;
  logic serialDin, serialBidirDataIn, serialDout, serialDoutOe, writeSeen;
  logic serialBidirDataOut, serialBidirDataOe;
  logic [7:0] cfgAddrSeen, q;
  int bad_count = 0, compares = 0;
  tscp_port i_tscp_port (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .csN(csN),
    .threeWire(threeWire),
    .serialDin(serialDin),
    .serialBidirDataIn(serialBidirDataIn),
    .serialDout(serialDout),
    .serialDoutOe(serialDoutOe),
    .serialBidirDataOut(serialBidirDataOut),
    .serialBidirDataOe(serialBidirDataOe),
    .cfgAddrSeen(cfgAddrSeen),
    .writeSeen(writeSeen)
  );
  tscp_master i_tscp_master (
    .threeWire(threeWire),
    .serialDout(serialDout),
    .serialDoutOe(serialDoutOe),
    .serialBidirDataOut(serialBidirDataOut),
    .serialBidirDataOe(serialBidirDataOe),
    .sclk(sclk),
    .csN(csN),
    .serialDin(serialDin),
    .serialBidirDataIn(serialBidirDataIn)
  );
  initial forever #5 clk = ~clk;
  task chk(input string n, input logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task report_and_stop;
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task xf(input logic r, input logic [14:0] a, input logic [7:0] d,
    input int n);
    hit = 1'b0;
    i_tscp_master.xfer({r, a, d}, n, q);
    repeat (8) begin
      @(negedge clk);
      hit |= writeSeen;
    end
    chk("write", hit, !r && n == 24);
    if (r) chk("read", q, d);
  endtask : xf
  task mode_pass(input logic tw);
    @(posedge clk);
    #1 threeWire = tw;
    xf(1'b1, 15'h0033, REG_RESET, 24);
    xf(1'b0, 15'h7f05, {7'h52, tw}, 24);
    xf(1'b0, 15'h0006, 8'h3c, 24);
    chk("addr", cfgAddrSeen, 8'h06);
    xf(1'b1, 15'h0005, {7'h52, tw}, 24);
  endtask : mode_pass
  task cut_frame;
    xf(1'b0, 15'h0007, 8'hff, 23);
    chk("addr", cfgAddrSeen, 8'h06);
    xf(1'b1, 15'h0007, REG_RESET, 24);
  endtask : cut_frame
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    mode_pass(1'b0);
    mode_pass(1'b1);
    cut_frame();
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule : testbench
